// >>> pkg/xad_cfg.svh
`ifndef XAD_CFG_SVH
`define XAD_CFG_SVH

// Register byte offsets
`define XAD_OFF_PAGE   8'h00
`define XAD_OFF_DPL    8'h04
`define XAD_OFF_DPH    8'h08
`define XAD_OFF_DATA_POINTER   8'h0C
`define XAD_OFF_CFG    8'h10
`define XAD_OFF_STAT   8'h14

// Configuration field positions
`define XAD_CFG_FWE    0
`define XAD_CFG_MODE_L 1
`define XAD_CFG_MODE_H 2
`define XAD_CFG_FAE    6

// Status field positions
`define XAD_ST_BUSY    0
`define XAD_ST_TGT_L   1
`define XAD_ST_TGT_H   2
`define XAD_ST_ADDR_L  16
`define XAD_ST_ADDR_H  31

// Reset values
`define XAD_PAGE_RST   8'h00
`define XAD_DATA_POINTER_RST   16'h0000
`define XAD_MODE_RST   2'h0

// Address map
`define XAD_FIFO_LO    16'h0400
`define XAD_FIFO_HI    16'h07FF
`define XAD_RAM4K_TOP  16'h0FFF
`define XAD_RAM2K_TOP  16'h07FF

// AXI answers
`define XAD_RESP_OKAY  2'h0
`define XAD_RESP_SLV   2'h2

// Timing
`define XAD_CLK_NS     10
`define XAD_FIFO_NS    30
`define XAD_FIFO_CYC   ((`XAD_FIFO_NS + `XAD_CLK_NS - 1) / `XAD_CLK_NS)

`endif

// >>> pkg/xad_pkg.sv
`include "xad_cfg.svh"

package xad_pkg;

	typedef enum logic [5:0] {
		ST_IDLE  = 6'h01,
		ST_RAM   = 6'h02,
		ST_FIFO  = 6'h04,
		ST_OFF   = 6'h08,
		ST_FLASH = 6'h10,
		ST_DONE  = 6'h20
	} xad_state_t;

	typedef enum logic [1:0] {
		TGT_RAM   = 2'h0,
		TGT_FIFO  = 2'h1,
		TGT_OFF   = 2'h2,
		TGT_FLASH = 2'h3
	} xad_target_t;

	typedef enum logic [1:0] {
		MODE_ONCHIP = 2'h0,
		MODE_SPLIT  = 2'h1,
		MODE_SPLITB = 2'h2,
		MODE_OFFCHP = 2'h3
	} xad_mode_t;

	function automatic logic in_fifo_win(input logic [15:0] a);
		return (a >= `XAD_FIFO_LO) && (a <= `XAD_FIFO_HI);
	endfunction : in_fifo_win

	function automatic logic [15:0] ram_top(input logic big);
		return big ? `XAD_RAM4K_TOP : `XAD_RAM2K_TOP;
	endfunction : ram_top

endpackage : xad_pkg

// >>> pkg/xad_reg_if.sv
`timescale 1ns/1ps

interface xad_reg_if;
	import xad_pkg::*;

	logic [7:0]  page;
	logic [15:0] data_pointer;
	logic        fifo_map;
	logic        flash_en;
	xad_mode_t   mode;
	logic        busy;
	xad_target_t last_tgt;
	logic [15:0] last_addr;

	modport regs (
		output page, data_pointer, fifo_map, flash_en, mode,
		input  busy, last_tgt, last_addr
	);
	modport dec (
		input page, data_pointer, fifo_map, flash_en, mode
	);
endinterface : xad_reg_if

// >>> hdl/xad_decode.sv
`timescale 1ns/1ps

module xad_decode import xad_pkg::*; #(
	parameter logic HAS_OFF = 1'b1,
	parameter logic RAM_4K  = 1'b1
) (
	input  wire logic        wide,
	input  wire logic        psel,
	input  wire logic [7:0]  ptr_zero,
	input  wire logic [7:0]  ptr_one,
	input  wire logic        wr,
	xad_reg_if.dec           rif,
	output logic      [15:0] addr,
	output xad_target_t      tgt
);

	always_comb begin
		if (wide) begin
			addr = rif.data_pointer;
		end else begin
			addr = {rif.page, psel ? ptr_one : ptr_zero};
		end
		// Flash path shares the address just built
		if (rif.flash_en && wr) begin
			tgt = TGT_FLASH;
		end else if (rif.fifo_map && in_fifo_win(addr)) begin
			tgt = TGT_FIFO;
		end else if (!HAS_OFF) begin
			tgt = TGT_RAM;
		end else begin
			unique case (rif.mode)
				MODE_ONCHIP: tgt = TGT_RAM;
				MODE_OFFCHP: tgt = TGT_OFF;
				MODE_SPLIT,
				MODE_SPLITB: tgt = (addr <= ram_top(RAM_4K)) ? TGT_RAM : TGT_OFF;
			endcase
		end
	end

endmodule : xad_decode

// >>> hdl/xad_axil.sv
`timescale 1ns/1ps

module xad_axil import xad_pkg::*; (
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic [7:0]  awaddr,
	input  wire logic        awvalid,
	output logic             awready,
	input  wire logic [31:0] wdata,
	input  wire logic [3:0]  wstrb,
	input  wire logic        wvalid,
	output logic             wready,
	output logic      [1:0]  bresp,
	output logic             bvalid,
	input  wire logic        bready,
	input  wire logic [7:0]  araddr,
	input  wire logic        arvalid,
	output logic             arready,
	output logic      [31:0] rdata,
	output logic      [1:0]  rresp,
	output logic             rvalid,
	input  wire logic        rready,
	xad_reg_if.regs          rif
);

	logic        aw_full_q, aw_full_d, w_full_q, w_full_d;
	logic [7:0]  aw_addr_q, aw_addr_d;
	logic [31:0] w_data_q, w_data_d, r_data_q, r_data_d;
	logic [3:0]  w_strb_q, w_strb_d;
	logic        b_valid_q, b_valid_d, r_valid_q, r_valid_d;
	logic [1:0]  b_resp_q, b_resp_d, r_resp_q, r_resp_d;
	logic [7:0]  page_q, page_d;
	logic [15:0] data_pointer_q, data_pointer_d;
	logic        fae_q, fae_d, fwe_q, fwe_d;
	xad_mode_t   mode_q, mode_d;

	// Writes stall while a response waits, so the register file sees one at a time
	assign awready = !aw_full_q && !b_valid_q;
	assign wready  = !w_full_q && !b_valid_q;
	assign arready = !r_valid_q;

	always_comb begin
		aw_full_d = aw_full_q;
		aw_addr_d = aw_addr_q;
		w_full_d  = w_full_q;
		w_data_d  = w_data_q;
		w_strb_d  = w_strb_q;
		b_valid_d = b_valid_q;
		b_resp_d  = b_resp_q;
		r_valid_d = r_valid_q;
		r_data_d  = r_data_q;
		r_resp_d  = r_resp_q;
		page_d    = page_q;
		data_pointer_d    = data_pointer_q;
		fae_d     = fae_q;
		fwe_d     = fwe_q;
		mode_d    = mode_q;
		if (awvalid && awready) begin
			aw_full_d = 1'b1;
			aw_addr_d = awaddr;
		end
		if (wvalid && wready) begin
			w_full_d = 1'b1;
			w_data_d = wdata;
			w_strb_d = wstrb;
		end
		if (b_valid_q && bready) begin
			b_valid_d = 1'b0;
		end
		if (aw_full_q && w_full_q) begin
			aw_full_d = 1'b0;
			w_full_d  = 1'b0;
			b_valid_d = 1'b1;
			b_resp_d  = `XAD_RESP_OKAY;
			case (aw_addr_q)
				`XAD_OFF_PAGE: if (w_strb_q[0]) page_d = w_data_q[7:0];
				`XAD_OFF_DPL:  if (w_strb_q[0]) data_pointer_d[7:0] = w_data_q[7:0];
				`XAD_OFF_DPH:  if (w_strb_q[0]) data_pointer_d[15:8] = w_data_q[7:0];
				`XAD_OFF_DATA_POINTER: begin
					if (w_strb_q[0]) data_pointer_d[7:0] = w_data_q[7:0];
					if (w_strb_q[1]) data_pointer_d[15:8] = w_data_q[15:8];
				end
				`XAD_OFF_CFG: begin
					if (w_strb_q[0]) begin
						fae_d  = w_data_q[`XAD_CFG_FAE];
						fwe_d  = w_data_q[`XAD_CFG_FWE];
						mode_d = xad_mode_t'(w_data_q[`XAD_CFG_MODE_H:`XAD_CFG_MODE_L]);
					end
				end
				`XAD_OFF_STAT: ;
				default: b_resp_d = `XAD_RESP_SLV;
			endcase
		end
		if (r_valid_q && rready) begin
			r_valid_d = 1'b0;
		end
		if (arvalid && arready) begin
			r_valid_d = 1'b1;
			r_data_d  = 32'h0000_0000;
			r_resp_d  = `XAD_RESP_OKAY;
			case (araddr)
				`XAD_OFF_PAGE: r_data_d[7:0]  = page_q;
				`XAD_OFF_DPL:  r_data_d[7:0]  = data_pointer_q[7:0];
				`XAD_OFF_DPH:  r_data_d[7:0]  = data_pointer_q[15:8];
				`XAD_OFF_DATA_POINTER: r_data_d[15:0] = data_pointer_q;
				`XAD_OFF_CFG: begin
					r_data_d[`XAD_CFG_FAE] = fae_q;
					r_data_d[`XAD_CFG_FWE] = fwe_q;
					r_data_d[`XAD_CFG_MODE_H:`XAD_CFG_MODE_L] = mode_q;
				end
				`XAD_OFF_STAT: begin
					r_data_d[`XAD_ST_BUSY] = rif.busy;
					r_data_d[`XAD_ST_TGT_H:`XAD_ST_TGT_L] = rif.last_tgt;
					r_data_d[`XAD_ST_ADDR_H:`XAD_ST_ADDR_L] = rif.last_addr;
				end
				default: r_resp_d = `XAD_RESP_SLV;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			aw_full_q <= 1'b0;
			aw_addr_q <= 8'h00;
			w_full_q  <= 1'b0;
			w_data_q  <= 32'h0000_0000;
			w_strb_q  <= 4'h0;
			b_valid_q <= 1'b0;
			b_resp_q  <= `XAD_RESP_OKAY;
			r_valid_q <= 1'b0;
			r_data_q  <= 32'h0000_0000;
			r_resp_q  <= `XAD_RESP_OKAY;
			page_q    <= `XAD_PAGE_RST;
			data_pointer_q    <= `XAD_DATA_POINTER_RST;
			fae_q     <= 1'b0;
			fwe_q     <= 1'b0;
			mode_q    <= xad_mode_t'(`XAD_MODE_RST);
		end else begin
			aw_full_q <= aw_full_d;
			aw_addr_q <= aw_addr_d;
			w_full_q  <= w_full_d;
			w_data_q  <= w_data_d;
			w_strb_q  <= w_strb_d;
			b_valid_q <= b_valid_d;
			b_resp_q  <= b_resp_d;
			r_valid_q <= r_valid_d;
			r_data_q  <= r_data_d;
			r_resp_q  <= r_resp_d;
			page_q    <= page_d;
			data_pointer_q    <= data_pointer_d;
			fae_q     <= fae_d;
			fwe_q     <= fwe_d;
			mode_q    <= mode_d;
		end
	end

	assign bvalid       = b_valid_q;
	assign bresp        = b_resp_q;
	assign rvalid       = r_valid_q;
	assign rdata        = r_data_q;
	assign rresp        = r_resp_q;
	assign rif.page     = page_q;
	assign rif.data_pointer     = data_pointer_q;
	assign rif.fifo_map = fae_q;
	assign rif.flash_en = fwe_q;
	assign rif.mode     = mode_q;

endmodule : xad_axil

// >>> hdl/xad_top.sv
// The register addresses and the AXI4-Lite register port were left to the implementer.
`timescale 1ns/1ps


module xad_top import xad_pkg::*; #(
	parameter logic HAS_OFF = 1'b1,
	parameter logic RAM_4K  = 1'b1
) (
	input  wire logic        MCLK,
	input  wire logic        RST,
	input  wire logic [7:0]  S_AXI_AWADDR,
	input  wire logic        S_AXI_AWVALID,
	output logic             S_AXI_AWREADY,
	input  wire logic [31:0] S_AXI_WDATA,
	input  wire logic [3:0]  S_AXI_WSTRB,
	input  wire logic        S_AXI_WVALID,
	output logic             S_AXI_WREADY,
	output logic      [1:0]  S_AXI_BRESP,
	output logic             S_AXI_BVALID,
	input  wire logic        S_AXI_BREADY,
	input  wire logic [7:0]  S_AXI_ARADDR,
	input  wire logic        S_AXI_ARVALID,
	output logic             S_AXI_ARREADY,
	output logic      [31:0] S_AXI_RDATA,
	output logic      [1:0]  S_AXI_RRESP,
	output logic             S_AXI_RVALID,
	input  wire logic        S_AXI_RREADY,
	input  wire logic        MV_REQ,
	input  wire logic        MV_WIDE,
	input  wire logic        MV_PSEL,
	input  wire logic [7:0]  MV_PTR_ZERO,
	input  wire logic [7:0]  MV_PTR_ONE,
	input  wire logic        MV_WR,
	input  wire logic [7:0]  MV_WDATA,
	output logic      [7:0]  MV_RDATA,
	output logic             MV_DONE,
	output logic             MV_STALL,
	output logic             FIFO_REQ,
	output logic             FIFO_WR,
	output logic      [9:0]  FIFO_ADDR,
	output logic      [7:0]  FIFO_WDATA,
	input  wire logic [7:0]  FIFO_RDATA,
	input  wire logic        FIFO_ACK,
	output logic             OFF_REQ,
	output logic             OFF_WR,
	output logic      [15:0] OFF_ADDR,
	output logic      [7:0]  OFF_WDATA,
	input  wire logic [7:0]  OFF_RDATA,
	input  wire logic        OFF_ACK,
	output logic             FLASH_WE,
	output logic      [15:0] FLASH_ADDR,
	output logic      [7:0]  FLASH_WDATA
);

	localparam logic [3:0] FIFO_CYC = 4'(`XAD_FIFO_CYC);

	xad_reg_if rif ();

	xad_state_t  state_q, state_d;
	xad_target_t tgt_q, tgt_d, dec_tgt;
	logic [15:0] addr_q, addr_d, dec_addr;
	logic [7:0]  wdata_q, wdata_d, rdata_q, rdata_d;
	logic        wr_q, wr_d;
	logic [3:0]  cnt_q, cnt_d;
	logic        got_q, got_d;
	logic        ram_we;
	logic [11:0] ram_idx;
	logic [7:0]  ram_q [0:4095];

	xad_axil u_axil (
		.clk     (MCLK),
		.rst     (RST),
		.awaddr  (S_AXI_AWADDR),
		.awvalid (S_AXI_AWVALID),
		.awready (S_AXI_AWREADY),
		.wdata   (S_AXI_WDATA),
		.wstrb   (S_AXI_WSTRB),
		.wvalid  (S_AXI_WVALID),
		.wready  (S_AXI_WREADY),
		.bresp   (S_AXI_BRESP),
		.bvalid  (S_AXI_BVALID),
		.bready  (S_AXI_BREADY),
		.araddr  (S_AXI_ARADDR),
		.arvalid (S_AXI_ARVALID),
		.arready (S_AXI_ARREADY),
		.rdata   (S_AXI_RDATA),
		.rresp   (S_AXI_RRESP),
		.rvalid  (S_AXI_RVALID),
		.rready  (S_AXI_RREADY),
		.rif     (rif.regs)
	);

	xad_decode #(
		.HAS_OFF (HAS_OFF),
		.RAM_4K  (RAM_4K)
	) u_decode (
		.wide     (MV_WIDE),
		.psel     (MV_PSEL),
		.ptr_zero (MV_PTR_ZERO),
		.ptr_one  (MV_PTR_ONE),
		.wr       (MV_WR),
		.rif      (rif.dec),
		.addr     (dec_addr),
		.tgt      (dec_tgt)
	);

	// Small variant aliases the upper half back onto the lower 2k
	assign ram_idx = RAM_4K ? addr_q[11:0] : {1'b0, addr_q[10:0]};

	always_comb begin
		state_d = state_q;
		tgt_d   = tgt_q;
		addr_d  = addr_q;
		wdata_d = wdata_q;
		wr_d    = wr_q;
		rdata_d = rdata_q;
		cnt_d   = cnt_q;
		got_d   = got_q;
		ram_we  = 1'b0;
		unique case (state_q)
			ST_IDLE: begin
				if (MV_REQ) begin
					addr_d  = dec_addr;
					tgt_d   = dec_tgt;
					wdata_d = MV_WDATA;
					wr_d    = MV_WR;
					unique case (dec_tgt)
						TGT_RAM:   state_d = ST_RAM;
						TGT_FIFO: begin
							state_d = ST_FIFO;
							cnt_d   = FIFO_CYC - 4'h1;
							got_d   = 1'b0;
						end
						TGT_OFF:   state_d = ST_OFF;
						TGT_FLASH: state_d = ST_FLASH;
					endcase
				end
			end
			ST_RAM: begin
				if (wr_q) begin
					ram_we = 1'b1;
				end else begin
					rdata_d = ram_q[ram_idx];
				end
				state_d = ST_DONE;
			end
			ST_FIFO: begin
				// Held for a floor of cycles: the FIFO RAM runs in the USB domain
				if (cnt_q != 4'h0) begin
					cnt_d = cnt_q - 4'h1;
				end
				if (FIFO_ACK && !got_q) begin
					got_d = 1'b1;
					if (!wr_q) begin
						rdata_d = FIFO_RDATA;
					end
				end
				if ((got_q || FIFO_ACK) && cnt_q == 4'h0) begin
					state_d = ST_DONE;
				end
			end
			ST_OFF: begin
				// No timeout: a missing acknowledge hangs the core, as real pins would
				if (OFF_ACK) begin
					if (!wr_q) begin
						rdata_d = OFF_RDATA;
					end
					state_d = ST_DONE;
				end
			end
			ST_FLASH: state_d = ST_DONE;
			ST_DONE:  state_d = ST_IDLE;
			default:  state_d = ST_IDLE;
		endcase
	end

	always_ff @(posedge MCLK) begin
		if (RST) begin
			state_q <= ST_IDLE;
			tgt_q   <= TGT_RAM;
			addr_q  <= 16'h0000;
			wdata_q <= 8'h00;
			wr_q    <= 1'b0;
			rdata_q <= 8'h00;
			cnt_q   <= 4'h0;
			got_q   <= 1'b0;
		end else begin
			state_q <= state_d;
			tgt_q   <= tgt_d;
			addr_q  <= addr_d;
			wdata_q <= wdata_d;
			wr_q    <= wr_d;
			rdata_q <= rdata_d;
			cnt_q   <= cnt_d;
			got_q   <= got_d;
		end
	end

	// RAM contents need no reset
	always_ff @(posedge MCLK) begin
		if (ram_we) begin
			ram_q[ram_idx] <= wdata_q;
		end
	end

	assign MV_RDATA    = rdata_q;
	assign MV_DONE     = (state_q == ST_DONE);
	assign MV_STALL    = MV_REQ && (state_q != ST_DONE);
	assign FIFO_REQ    = (state_q == ST_FIFO) && !got_q;
	assign FIFO_WR     = wr_q;
	assign FIFO_ADDR   = addr_q[9:0];
	assign FIFO_WDATA  = wdata_q;
	assign OFF_REQ     = (state_q == ST_OFF);
	assign OFF_WR      = wr_q;
	assign OFF_ADDR    = addr_q;
	assign OFF_WDATA   = wdata_q;
	assign FLASH_WE    = (state_q == ST_FLASH);
	assign FLASH_ADDR  = addr_q;
	assign FLASH_WDATA = wdata_q;

	assign rif.busy      = (state_q != ST_IDLE);
	assign rif.last_tgt  = tgt_q;
	assign rif.last_addr = addr_q;

	default clocking cb @(posedge MCLK);
	endclocking
	default disable iff (RST);

	a_wide_addr: assert property (
		(state_q == ST_IDLE && MV_REQ && MV_WIDE) |=> addr_q == $past(rif.data_pointer))
		else $error("wide move address differs from data pointer");

	a_page_addr: assert property (
		(state_q == ST_IDLE && MV_REQ && !MV_WIDE) |=>
		(addr_q[15:8] == $past(rif.page)) &&
		(addr_q[7:0] == ($past(MV_PSEL) ? $past(MV_PTR_ONE) : $past(MV_PTR_ZERO))))
		else $error("short move address not page plus pointer");

	a_fifo_window: assert property (
		(state_q == ST_IDLE && MV_REQ && rif.fifo_map && !(rif.flash_en && MV_WR)
		&& in_fifo_win(dec_addr)) |=> state_q == ST_FIFO ##0 FIFO_REQ)
		else $error("mapped window move did not reach FIFO RAM");

	a_fifo_hides: assert property (
		(state_q == ST_IDLE && MV_REQ && rif.fifo_map && in_fifo_win(dec_addr)) |=>
		(state_q != ST_RAM) && !OFF_REQ)
		else $error("hidden memory reached inside mapped window");

	a_fifo_slow: assert property (
		$rose(state_q == ST_FIFO) |-> (MV_STALL && state_q == ST_FIFO)[*3])
		else $error("FIFO move shorter than its cycle floor");

	a_flash_path: assert property (
		(state_q == ST_IDLE && MV_REQ && rif.flash_en && MV_WR) |=>
		FLASH_WE ##1 (MV_DONE && !FLASH_WE))
		else $error("flash write path not taken");

	a_no_flash: assert property (
		(state_q == ST_IDLE && MV_REQ && !rif.flash_en) |=> !FLASH_WE ##1 !FLASH_WE)
		else $error("flash written with path disabled");

	a_ram_onchip: assert property (
		(state_q == ST_IDLE && MV_REQ && rif.mode == MODE_ONCHIP && !rif.fifo_map
		&& !rif.flash_en) |=> (state_q == ST_RAM) ##1 MV_DONE)
		else $error("on-chip mode move missed the RAM");

	a_off_mode: assert property (
		$rose(OFF_REQ) |-> HAS_OFF && ($past(rif.mode) != MODE_ONCHIP))
		else $error("off-chip port used in on-chip mode");

endmodule : xad_top

// >>> tb/xad_mem_model.sv
`timescale 1ns/1ps

module xad_mem_model (
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic [3:0]  fifo_dly,
	input  wire logic [3:0]  off_dly,
	input  wire logic        fifo_req,
	input  wire logic        fifo_wr,
	input  wire logic [9:0]  fifo_addr,
	input  wire logic [7:0]  fifo_wdata,
	output logic      [7:0]  fifo_rdata,
	output logic             fifo_ack,
	input  wire logic        off_req,
	input  wire logic        off_wr,
	input  wire logic [15:0] off_addr,
	input  wire logic [7:0]  off_wdata,
	output logic      [7:0]  off_rdata,
	output logic             off_ack
);
	logic [7:0] fifo_mem [0:1023];
	logic [7:0] off_mem  [0:65535];
	logic [3:0] fcnt_q;
	logic [3:0] ocnt_q;
	logic [7:0] flast_q;
	logic [7:0] olast_q;

	// Always answers, so the USB side clock is taken as running
	assign fifo_ack   = fifo_req && (fcnt_q == fifo_dly);
	assign off_ack    = off_req && (ocnt_q == off_dly);
	// Idle data lines show inverted last byte, never a stale match
	assign fifo_rdata = fifo_ack ? fifo_mem[fifo_addr] : ~flast_q;
	assign off_rdata  = off_ack ? off_mem[off_addr] : ~olast_q;

	always @(posedge clk) begin
		fcnt_q <= (rst || !fifo_req || fifo_ack) ? 4'h0 : fcnt_q + 4'h1;
		ocnt_q <= (rst || !off_req || off_ack) ? 4'h0 : ocnt_q + 4'h1;
		if (rst) begin
			flast_q <= 8'h00;
			olast_q <= 8'h00;
		end
		if (fifo_ack) begin
			flast_q <= fifo_rdata;
			if (fifo_wr) fifo_mem[fifo_addr] <= fifo_wdata;
		end
		if (off_ack) begin
			olast_q <= off_rdata;
			if (off_wr) off_mem[off_addr] <= off_wdata;
		end
	end
endmodule : xad_mem_model

// >>> tb/xad_top_test.sv
`timescale 1ns/1ps

module xad_top_test;
	typedef struct packed {
		logic [7:0]  cfg;
		logic [7:0]  page;
		logic [15:0] data_pointer;
		logic [2:0]  fl;
		logic [7:0]  ptr;
		logic [1:0]  tgt;
		logic [15:0] addr;
	} xad_row_t;

	logic        mclk = 1'h0;
	logic        rst  = 1'h1;
	logic [7:0]  awa  = 8'h00;
	logic        awv  = 1'h0;
	logic [31:0] wd   = 32'h0;
	logic        wv   = 1'h0;
	logic        brd  = 1'h0;
	logic [7:0]  ara  = 8'h00;
	logic        arv  = 1'h0;
	logic        rrd  = 1'h0;
	logic        mreq = 1'h0;
	logic        mwd_ = 1'h0;
	logic        mps  = 1'h0;
	logic [7:0]  mp0  = 8'h00;
	logic [7:0]  mp1  = 8'h00;
	logic        mwr  = 1'h0;
	logic [7:0]  mwd  = 8'h00;
	logic [3:0]  fdly = 4'h0;
	logic [3:0]  odly = 4'h0;
	logic        awr, wrdy, bv, arr, rv, mdone, mstall, freq, fwr, fack, oreq, owr, oack, fwe;
	logic [1:0]  bresp, rresp;
	logic [31:0] rdat;
	logic [7:0]  mrd, fwd, frd, owd, ord, flwd;
	logic [9:0]  fadr;
	logic [15:0] oadr, fladr;
	logic [15:0] fl_last = 16'h0;
	logic [7:0]  fl_wd   = 8'h00;
	int          err_count = 0;
	int          n_checks = 0;

	xad_row_t rows [16] = '{
		'{8'h00, 8'h00, 16'h1234, 3'h4, 8'h00, 2'h0, 16'h1234},
		'{8'h00, 8'h12, 16'h0000, 3'h0, 8'h34, 2'h0, 16'h1234},
		'{8'h00, 8'h12, 16'h0000, 3'h2, 8'h56, 2'h0, 16'h1256},
		'{8'h40, 8'h00, 16'h0400, 3'h4, 8'h00, 2'h1, 16'h0400},
		'{8'h40, 8'h07, 16'h0000, 3'h2, 8'hFF, 2'h1, 16'h07FF},
		'{8'h40, 8'h00, 16'h03FF, 3'h4, 8'h00, 2'h0, 16'h03FF},
		'{8'h40, 8'h00, 16'h0800, 3'h4, 8'h00, 2'h0, 16'h0800},
		'{8'h06, 8'h00, 16'h0500, 3'h4, 8'h00, 2'h2, 16'h0500},
		'{8'h46, 8'h00, 16'h0500, 3'h4, 8'h00, 2'h1, 16'h0500},
		'{8'h02, 8'h00, 16'h0FFF, 3'h4, 8'h00, 2'h0, 16'h0FFF},
		'{8'h02, 8'h00, 16'h1000, 3'h4, 8'h00, 2'h2, 16'h1000},
		'{8'h04, 8'h00, 16'h1000, 3'h4, 8'h00, 2'h2, 16'h1000},
		'{8'h01, 8'h00, 16'h2000, 3'h5, 8'h00, 2'h3, 16'h2000},
		'{8'h01, 8'h00, 16'h2000, 3'h4, 8'h00, 2'h0, 16'h2000},
		'{8'h41, 8'h00, 16'h0450, 3'h5, 8'h00, 2'h3, 16'h0450},
		'{8'h00, 8'h04, 16'h0000, 3'h1, 8'h50, 2'h0, 16'h0450}
	};

	always #5 mclk = ~mclk;

	always @(posedge mclk) begin
		if (fwe === 1'h1) begin
			fl_last <= fladr;
			fl_wd   <= flwd;
		end
	end

	xad_top #(.HAS_OFF(1'h1), .RAM_4K(1'h1)) uut (
		.MCLK(mclk), .RST(rst), .S_AXI_AWADDR(awa), .S_AXI_AWVALID(awv),
		.S_AXI_AWREADY(awr), .S_AXI_WDATA(wd), .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wv),
		.S_AXI_WREADY(wrdy), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bv), .S_AXI_BREADY(brd),
		.S_AXI_ARADDR(ara), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr), .S_AXI_RDATA(rdat),
		.S_AXI_RRESP(rresp), .S_AXI_RVALID(rv), .S_AXI_RREADY(rrd), .MV_REQ(mreq),
		.MV_WIDE(mwd_), .MV_PSEL(mps), .MV_PTR_ZERO(mp0), .MV_PTR_ONE(mp1), .MV_WR(mwr),
		.MV_WDATA(mwd), .MV_RDATA(mrd), .MV_DONE(mdone), .MV_STALL(mstall),
		.FIFO_REQ(freq), .FIFO_WR(fwr), .FIFO_ADDR(fadr), .FIFO_WDATA(fwd),
		.FIFO_RDATA(frd), .FIFO_ACK(fack), .OFF_REQ(oreq), .OFF_WR(owr), .OFF_ADDR(oadr),
		.OFF_WDATA(owd), .OFF_RDATA(ord), .OFF_ACK(oack), .FLASH_WE(fwe),
		.FLASH_ADDR(fladr), .FLASH_WDATA(flwd)
	);

	xad_mem_model mem (
		.clk(mclk), .rst(rst), .fifo_dly(fdly), .off_dly(odly), .fifo_req(freq),
		.fifo_wr(fwr), .fifo_addr(fadr), .fifo_wdata(fwd), .fifo_rdata(frd),
		.fifo_ack(fack), .off_req(oreq), .off_wr(owr), .off_addr(oadr),
		.off_wdata(owd), .off_rdata(ord), .off_ack(oack)
	);

	task stop_test;
		$display("checks %0d errors %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask : stop_test

	task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
		n_checks++;
		if (s !== e) begin
			err_count++;
			$display("BAD %s expected %h seen %h", nm, e, s);
		end
	endtask : chk

	// Bounded waits: a hang counts as a mismatch and ends the run
	task axi_wr(input logic [7:0] a, input logic [31:0] d);
		int i;
		@(posedge mclk);
		awa <= a; awv <= 1'h1; wd <= d; wv <= 1'h1; brd <= 1'h1;
		for (i = 0; i < 50; i++) begin
			@(posedge mclk);
			if (awr) awv <= 1'h0;
			if (wrdy) wv <= 1'h0;
			if (bv === 1'h1) break;
		end
		brd <= 1'h0;
		if (i == 50) begin chk("bwait", 0, 1); stop_test; end
	endtask : axi_wr

	task axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		int i;
		@(posedge mclk);
		ara <= a; arv <= 1'h1; rrd <= 1'h1;
		for (i = 0; i < 50; i++) begin
			@(posedge mclk);
			if (arr) arv <= 1'h0;
			if (rv === 1'h1) break;
		end
		d = rdat;
		r = rresp;
		rrd <= 1'h0;
		if (i == 50) begin chk("rwait", 0, 1); stop_test; end
	endtask : axi_rd

	// Flags: wide, pointer one, write; the unused pointer gets the inverse
	task mv(input logic [2:0] fl, input logic [7:0] p, input logic [7:0] w,
		output logic [7:0] rd, output int n);
		@(posedge mclk);
		mreq <= 1'h1; mwd_ <= fl[2]; mps <= fl[1]; mwr <= fl[0]; mwd <= w;
		mp0 <= fl[1] ? ~p : p;
		mp1 <= fl[1] ? p : ~p;
		for (n = 0; n < 40; n++) begin
			@(posedge mclk);
			if (n == 1) chk("stall", mstall, 1'h1);
			if (mdone === 1'h1) break;
		end
		rd = mrd;
		mreq <= 1'h0;
		if (n == 40) begin chk("mwait", 0, 1); stop_test; end
	endtask : mv

	task setup(input logic [7:0] cfg, input logic [7:0] pg, input logic [15:0] dp);
		axi_wr(8'h00, {24'h0, pg});
		axi_wr(8'h0C, {16'h0, dp});
		axi_wr(8'h10, {24'h0, cfg});
	endtask : setup

	initial begin
		logic [31:0] v;
		logic [1:0]  r;
		logic [7:0]  d;
		int          n;
		repeat (2) @(posedge mclk);
		rst <= 1'h0;
		for (int a = 0; a < 20; a += 4) begin
			axi_rd(8'(a), v, r);
			chk("reset value", v, 0);
		end
		axi_rd(8'h18, v, r);
		chk("unmapped resp", r, 2'h2);
		axi_wr(8'h0C, 32'h0000ABCD);
		axi_rd(8'h08, v, r);
		chk("high byte", v, 32'hAB);
		axi_rd(8'h04, v, r);
		chk("low byte", v, 32'hCD);
		axi_wr(8'h04, 32'h00000011);
		axi_rd(8'h0C, v, r);
		chk("pointer", v, 32'hAB11);
		foreach (rows[k]) begin
			setup(rows[k].cfg, rows[k].page, rows[k].data_pointer);
			mv(rows[k].fl, rows[k].ptr, 8'hA5, d, n);
			axi_rd(8'h14, v, r);
			chk("target", v[2:1], rows[k].tgt);
			chk("address", v[31:16], rows[k].addr);
			if (rows[k].tgt == 2'h3) chk("flash addr", fl_last, rows[k].addr);
			if (rows[k].tgt == 2'h3) chk("flash data", fl_wd, 8'hA5);
		end
		// Cycle counts from take edge to done
		setup(8'h00, 8'h00, 16'h0123);
		mv(3'h5, 8'h00, 8'h77, d, n);
		chk("ram cycles", n, 2);
		mv(3'h4, 8'h00, 8'h00, d, n);
		chk("ram data", d, 8'h77);
		// Map enable set first; only an unused FIFO byte is used as storage
		setup(8'h40, 8'h00, 16'h0450);
		mv(3'h5, 8'h00, 8'h5A, d, n);
		chk("fifo cycles", n, 4);
		chk("fifo store", mem.fifo_mem[10'h050], 8'h5A);
		fdly <= 4'h6;
		mv(3'h4, 8'h00, 8'h00, d, n);
		chk("fifo late ack", n, 8);
		chk("fifo data", d, 8'h5A);
		setup(8'h06, 8'h00, 16'h3000);
		odly <= 4'h5;
		mv(3'h5, 8'h00, 8'hC3, d, n);
		chk("off cycles", n, 7);
		chk("off store", mem.off_mem[16'h3000], 8'hC3);
		mv(3'h4, 8'h00, 8'h00, d, n);
		chk("off data", d, 8'hC3);
		// Reset in mid-run must clear configuration again
		@(posedge mclk);
		rst <= 1'h1;
		repeat (2) @(posedge mclk);
		rst <= 1'h0;
		axi_rd(8'h10, v, r);
		chk("cfg after reset", v, 0);
		axi_rd(8'h0C, v, r);
		chk("ptr after reset", v, 0);
		stop_test;
	end
endmodule : xad_top_test
